/* File: src/drs_supervisor.sv */
`timescale 1ns/10ps


// ============================================================================
// dual reset supervisor: two independent channels
// ============================================================================
// each channel: pin conditioning, a cause term, then a timeout counter
// latency budget per channel, in clock cycles:
//   supply falling to reset asserted: 2 sync + 20 filter + 1 register
//   manual low to reset asserted: 2 sync + 100 debounce + 1 register
//   last cause clearing to release: the same filter latency plus a full count
// the filters only add delay ahead of the counter, so every timeout is a minimum
// limitation: manual pulses shorter than 5 us are ignored here, which lies
// inside the promised range between the rejected and the accepted widths
// hazard: the counter restarts on every cause, so a supply that chatters for
// longer than the filter keeps the output asserted indefinitely, which is safe
// trade-off: one shared filter width keeps the logic small; hold counts beyond
// 256 cycles need the package width raised
// trade-off: both channels use separate counters rather than one shared
// prescaler, which costs flops but keeps the channels free of common state
// the cycle counts can be overridden for short simulation runs; the selects
// then only document the intended build
module drs_supervisor #(
  parameter drs_pkg::drs_timeout_t TIMEOUT_SEL_CH1 = drs_pkg::DRS_TIMEOUT_140MS,
  parameter drs_pkg::drs_timeout_t TIMEOUT_SEL_CH2 = drs_pkg::DRS_TIMEOUT_140MS,
  parameter int unsigned           TIMEOUT_CYC_CH1 = drs_pkg::drs_timeout_cycles(TIMEOUT_SEL_CH1),
  parameter int unsigned           TIMEOUT_CYC_CH2 = drs_pkg::drs_timeout_cycles(TIMEOUT_SEL_CH2)
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // channel 1 inputs; the supply level is the comparator result, high = above threshold
  input  wire logic monitored_supply_ch1,
  input  wire logic manual_reset_n_ch1,
  input  wire logic manual_reset_n_ch1_oe,
  // channel 1 open-drain reset output
  output logic      reset_out_n_ch1,
  output logic      reset_out_n_ch1_oe,
  // channel 2 inputs, same meaning as channel 1
  input  wire logic monitored_supply_ch2,
  input  wire logic manual_reset_n_ch2,
  input  wire logic manual_reset_n_ch2_oe,
  // channel 2 open-drain reset output
  output logic      reset_out_n_ch2,
  output logic      reset_out_n_ch2_oe
);
  import drs_pkg::*;

  localparam logic [TIMER_WIDTH-1:0] LAST_CH1 = TIMER_WIDTH'(TIMEOUT_CYC_CH1 - 1);
  localparam logic [TIMER_WIDTH-1:0] LAST_CH2 = TIMER_WIDTH'(TIMEOUT_CYC_CH2 - 1);

  // manual pin levels with the pull-up applied
  logic mr_pin_ch1;
  logic mr_pin_ch2;

  // filtered levels
  logic supply_ok_ch1;
  logic supply_ok_ch2;
  logic mr_clean_ch1;
  logic mr_clean_ch2;

  // combined reset cause per channel
  logic cause_ch1;
  logic cause_ch2;

  // ==========================================================================
  // pin conditioning
  // ==========================================================================
  // undriven pin reads high, as the pull-up would make it; the mux sits ahead of
  // the synchroniser so no pin level reaches logic unsynchronised
  assign mr_pin_ch1 = manual_reset_n_ch1_oe ? manual_reset_n_ch1 : 1'b1;
  assign mr_pin_ch2 = manual_reset_n_ch2_oe ? manual_reset_n_ch2 : 1'b1;

  // supply filter resets to "low" so the output is asserted from power-on
  drs_filter #(
    .HOLD_CYCLES (SUPPLY_FILTER_CYCLES),
    .RESET_LEVEL (1'b0)
  ) u_supply_ch1 (
    .clock     (clock),
    .rst_n     (rst_n),
    .raw_in    (monitored_supply_ch1),
    .level_out (supply_ok_ch1)
  );

  drs_filter #(
    .HOLD_CYCLES (SUPPLY_FILTER_CYCLES),
    .RESET_LEVEL (1'b0)
  ) u_supply_ch2 (
    .clock     (clock),
    .rst_n     (rst_n),
    .raw_in    (monitored_supply_ch2),
    .level_out (supply_ok_ch2)
  );

  // debounce sits between reject width and min pulse width
  drs_filter #(
    .HOLD_CYCLES (MR_DEBOUNCE_CYCLES),
    .RESET_LEVEL (1'b1)
  ) u_mr_ch1 (
    .clock     (clock),
    .rst_n     (rst_n),
    .raw_in    (mr_pin_ch1),
    .level_out (mr_clean_ch1)
  );

  drs_filter #(
    .HOLD_CYCLES (MR_DEBOUNCE_CYCLES),
    .RESET_LEVEL (1'b1)
  ) u_mr_ch2 (
    .clock     (clock),
    .rst_n     (rst_n),
    .raw_in    (mr_pin_ch2),
    .level_out (mr_clean_ch2)
  );

  // either cause holds its own channel in reset; chained supervisors enter here
  function automatic logic drs_cause(input logic supply_ok, input logic mr_clean);
    return !supply_ok || !mr_clean;
  endfunction : drs_cause

  assign cause_ch1 = drs_cause(supply_ok_ch1, mr_clean_ch1);
  assign cause_ch2 = drs_cause(supply_ok_ch2, mr_clean_ch2);

  // ==========================================================================
  // channel 1 timeout
  // ==========================================================================
  // counter width covers the longest timeout choice
  logic [TIMER_WIDTH-1:0] timer_ch1;
  logic [TIMER_WIDTH-1:0] next_timer_ch1;
  logic                   asserted_ch1;
  logic                   next_asserted_ch1;

  // any cause clears the count; otherwise count to the last value, then release
  always_comb begin
    next_timer_ch1    = timer_ch1;
    next_asserted_ch1 = asserted_ch1;
    if (cause_ch1) begin
      next_timer_ch1    = '0;
      next_asserted_ch1 = 1'b1;
    end else if (asserted_ch1) begin
      if (timer_ch1 == LAST_CH1) begin
        next_asserted_ch1 = 1'b0;
      end else begin
        next_timer_ch1 = timer_ch1 + TIMER_WIDTH'(1);
      end
    end
  end

  // registers only; reset asserts the output
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timer_ch1    <= '0;
      asserted_ch1 <= 1'b1;
    end else begin
      timer_ch1    <= next_timer_ch1;
      asserted_ch1 <= next_asserted_ch1;
    end
  end

  // ==========================================================================
  // channel 2 timeout, separate state from channel 1
  // ==========================================================================
  // counter width covers the longest timeout choice
  logic [TIMER_WIDTH-1:0] timer_ch2;
  logic [TIMER_WIDTH-1:0] next_timer_ch2;
  logic                   asserted_ch2;
  logic                   next_asserted_ch2;

  // any cause clears the count; otherwise count to the last value, then release
  always_comb begin
    next_timer_ch2    = timer_ch2;
    next_asserted_ch2 = asserted_ch2;
    if (cause_ch2) begin
      next_timer_ch2    = '0;
      next_asserted_ch2 = 1'b1;
    end else if (asserted_ch2) begin
      if (timer_ch2 == LAST_CH2) begin
        next_asserted_ch2 = 1'b0;
      end else begin
        next_timer_ch2 = timer_ch2 + TIMER_WIDTH'(1);
      end
    end
  end

  // registers only; reset asserts the output
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timer_ch2    <= '0;
      asserted_ch2 <= 1'b1;
    end else begin
      timer_ch2    <= next_timer_ch2;
      asserted_ch2 <= next_asserted_ch2;
    end
  end

  // ==========================================================================
  // open-drain outputs: data is always low, enable drives only when asserted
  // ==========================================================================
  // the pin never drives high, so the outside pull-up sets the released level
  // and the line may be pulled to another supply
  assign reset_out_n_ch1    = 1'b0;
  assign reset_out_n_ch1_oe = asserted_ch1;

  // channel 2 follows only its own asserted flop
  assign reset_out_n_ch2    = 1'b0;
  assign reset_out_n_ch2_oe = asserted_ch2;

endmodule : drs_supervisor

/* File: src/drs_pkg.sv */
package drs_pkg;

  // ==========================================================================
  // clock and timing
  // ==========================================================================
  localparam int unsigned CLOCK_PERIOD_NS      = 50;
  localparam int unsigned TIMEOUT_20_MS        = 20;
  localparam int unsigned TIMEOUT_140_MS       = 140;
  localparam int unsigned TIMEOUT_1100_MS      = 1100;
  localparam int unsigned MR_MIN_PULSE_US      = 10;
  localparam int unsigned MR_REJECT_PULSE_NS   = 100;
  localparam int unsigned SUPPLY_GLITCH_NS     = 1000;

  // least times round up
  localparam int unsigned TIMEOUT_20_CYCLES    = (TIMEOUT_20_MS * 1000000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned TIMEOUT_140_CYCLES   = (TIMEOUT_140_MS * 1000000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned TIMEOUT_1100_CYCLES  = (TIMEOUT_1100_MS * 1000000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  // debounce must exceed the reject width and stay well inside the min pulse
  localparam int unsigned MR_REJECT_CYCLES     = (MR_REJECT_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned MR_MIN_CYCLES        = (MR_MIN_PULSE_US * 1000) / CLOCK_PERIOD_NS;
  localparam int unsigned MR_DEBOUNCE_CYCLES   = MR_MIN_CYCLES / 2;
  localparam int unsigned SUPPLY_FILTER_CYCLES = (SUPPLY_GLITCH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  localparam int unsigned TIMER_WIDTH          = 26;
  localparam int unsigned FILTER_WIDTH         = 8;

  // ==========================================================================
  // timeout selection
  // ==========================================================================
  typedef enum logic [1:0] {
    DRS_TIMEOUT_20MS,
    DRS_TIMEOUT_140MS,
    DRS_TIMEOUT_1100MS
  } drs_timeout_t;

  function automatic int unsigned drs_timeout_cycles(input drs_timeout_t sel);
    case (sel)
      DRS_TIMEOUT_20MS:   return TIMEOUT_20_CYCLES;
      DRS_TIMEOUT_140MS:  return TIMEOUT_140_CYCLES;
      default:            return TIMEOUT_1100_CYCLES;
    endcase
  endfunction : drs_timeout_cycles

endpackage : drs_pkg

/* File: src/drs_filter.sv */
`timescale 1ns/10ps

// ============================================================================
// input filter: synchronise then accept a level only after it holds steadily
// ============================================================================
module drs_filter #(
  parameter int unsigned HOLD_CYCLES = 4,
  parameter logic        RESET_LEVEL = 1'b0
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // raw asynchronous level in
  input  wire logic raw_in,
  // filtered level out
  output logic      level_out
);
  import drs_pkg::*;

  localparam logic [FILTER_WIDTH-1:0] HOLD_LAST = FILTER_WIDTH'(HOLD_CYCLES - 1);

  logic                    sync_first;
  logic                    sync_second;
  logic [FILTER_WIDTH-1:0] count;
  logic [FILTER_WIDTH-1:0] next_count;
  logic                    next_level_out;

  // ==========================================================================
  // next state: a change must persist HOLD_CYCLES before it is taken
  // ==========================================================================
  always_comb begin
    next_count     = '0;
    next_level_out = level_out;
    if (sync_second != level_out) begin
      if (count == HOLD_LAST) begin
        next_level_out = sync_second;
      end else begin
        next_count = count + FILTER_WIDTH'(1);
      end
    end
  end

  // two-flop synchroniser; the first flop feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_first  <= RESET_LEVEL;
      sync_second <= RESET_LEVEL;
      count       <= '0;
      level_out   <= RESET_LEVEL;
    end else begin
      sync_first  <= raw_in;
      sync_second <= sync_first;
      count       <= next_count;
      level_out   <= next_level_out;
    end
  end

endmodule : drs_filter

/* File: sim/drs_reset_sink.sv */
`timescale 1ns/10ps
// ============================================================================
// reset sink: far-side reset input with its board pull-up
// ============================================================================
module drs_reset_sink (
  // open-drain drive from both channels
  input  wire logic drive_ch1,
  input  wire logic oe_ch1,
  input  wire logic drive_ch2,
  input  wire logic oe_ch2,
  // resolved line levels seen by the processor
  output logic      line_ch1,
  output logic      line_ch2
);
  // a released line floats up to the pull-up level
  assign line_ch1 = oe_ch1 ? drive_ch1 : 1'b1;
  assign line_ch2 = oe_ch2 ? drive_ch2 : 1'b1;
endmodule : drs_reset_sink

/* File: sim/drs_supervisor_asserts.sv */
`timescale 1ns/10ps
// ============================================================================
// checker on the supervisor pins
// ============================================================================
module drs_supervisor_asserts #(
  parameter int unsigned TIMEOUT_CYC_CH1 = 50,
  parameter int unsigned TIMEOUT_CYC_CH2 = 50
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic monitored_supply_ch1,
  input wire logic manual_reset_n_ch1,
  input wire logic manual_reset_n_ch1_oe,
  input wire logic reset_out_n_ch1,
  input wire logic reset_out_n_ch1_oe,
  input wire logic monitored_supply_ch2,
  input wire logic manual_reset_n_ch2,
  input wire logic manual_reset_n_ch2_oe,
  input wire logic reset_out_n_ch2,
  input wire logic reset_out_n_ch2_oe
);
  int   hi1, hi2, slo1, mlo1, mlo2;
  logic mr1, mr2;
  // pin level with the pull-up; undriven reads inactive
  assign mr1 = !(manual_reset_n_ch1_oe && !manual_reset_n_ch1);
  assign mr2 = !(manual_reset_n_ch2_oe && !manual_reset_n_ch2);
  // run lengths of cause-free and cause-present cycles, clamped to stay small
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {hi1, hi2, slo1, mlo1, mlo2} <= '0;
    end else begin
      hi1  <= !(monitored_supply_ch1 && mr1) ? 0 : (hi1 < 5000 ? hi1 + 1 : hi1);
      hi2  <= !(monitored_supply_ch2 && mr2) ? 0 : (hi2 < 5000 ? hi2 + 1 : hi2);
      slo1 <= monitored_supply_ch1 ? 0 : (slo1 < 500 ? slo1 + 1 : slo1);
      mlo1 <= mr1 ? 0 : (mlo1 < 500 ? mlo1 + 1 : mlo1);
      mlo2 <= mr2 ? 0 : (mlo2 < 500 ? mlo2 + 1 : mlo2);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_rst_rel;
    $rose(rst_n);
  endsequence
  a_data_low: assert property (!reset_out_n_ch1 && !reset_out_n_ch2) else $error("reset data not low");
  a_por_assert: assert property (s_rst_rel |-> reset_out_n_ch1_oe && reset_out_n_ch2_oe)
    else $error("no power-on reset");
  a_sup_assert: assert property (slo1 == 26 |-> reset_out_n_ch1_oe) else $error("supply low not seen");
  a_mr_assert1: assert property (mlo1 == 110 |-> reset_out_n_ch1_oe) else $error("manual 1 missed");
  a_mr_assert2: assert property (mlo2 == 110 |-> reset_out_n_ch2_oe) else $error("manual 2 missed");
  a_hold_min1: assert property ($fell(reset_out_n_ch1_oe) |-> hi1 >= TIMEOUT_CYC_CH1)
    else $error("release 1 early");
  a_hold_min2: assert property ($fell(reset_out_n_ch2_oe) |-> hi2 >= TIMEOUT_CYC_CH2)
    else $error("release 2 early");
  a_rel_max1: assert property (hi1 == TIMEOUT_CYC_CH1 + 120 |-> !reset_out_n_ch1_oe) else $error("stuck 1");
  a_rel_max2: assert property (hi2 == TIMEOUT_CYC_CH2 + 120 |-> !reset_out_n_ch2_oe) else $error("stuck 2");
endmodule : drs_supervisor_asserts

bind drs_supervisor drs_supervisor_asserts #(.TIMEOUT_CYC_CH1(TIMEOUT_CYC_CH1), .TIMEOUT_CYC_CH2(TIMEOUT_CYC_CH2))
  u_asserts (.clock(clock), .rst_n(rst_n), .monitored_supply_ch1(monitored_supply_ch1),
    .manual_reset_n_ch1(manual_reset_n_ch1), .manual_reset_n_ch1_oe(manual_reset_n_ch1_oe),
    .reset_out_n_ch1(reset_out_n_ch1), .reset_out_n_ch1_oe(reset_out_n_ch1_oe),
    .monitored_supply_ch2(monitored_supply_ch2), .manual_reset_n_ch2(manual_reset_n_ch2),
    .manual_reset_n_ch2_oe(manual_reset_n_ch2_oe), .reset_out_n_ch2(reset_out_n_ch2),
    .reset_out_n_ch2_oe(reset_out_n_ch2_oe));

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
// ============================================================================
// bench: short timeouts keep the run small
// ============================================================================
module tb_top;
  localparam int T1 = 300;
  localparam int T2 = 400;
  localparam int LS = 26;  // supply filter latency margin
  localparam int LM = 106; // manual debounce latency margin
  logic        clock, rst_n, sup1, sup2, mr1, mr1_oe, mr2, mr2_oe, rn1, oe1, rn2, oe2, line1, line2;
  int          n_fail, tests_run, cyc, len, exp_cyc;
  logic [31:0] rs;
  drs_supervisor #(.TIMEOUT_CYC_CH1(T1), .TIMEOUT_CYC_CH2(T2)) u_dut (.clock(clock), .rst_n(rst_n),
    .monitored_supply_ch1(sup1), .manual_reset_n_ch1(mr1), .manual_reset_n_ch1_oe(mr1_oe),
    .reset_out_n_ch1(rn1), .reset_out_n_ch1_oe(oe1), .monitored_supply_ch2(sup2), .manual_reset_n_ch2(mr2),
    .manual_reset_n_ch2_oe(mr2_oe), .reset_out_n_ch2(rn2), .reset_out_n_ch2_oe(oe2));
  drs_reset_sink u_sink (.drive_ch1(rn1), .oe_ch1(oe1), .drive_ch2(rn2), .oe_ch2(oe2),
    .line_ch1(line1), .line_ch2(line2));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd
  task automatic ticks(input int n);
    repeat (n) @(negedge clock);
  endtask : ticks
  task automatic chk(input string nm, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %b got %b", nm, exp, got);
    end
  endtask : chk
  // model: line must stay low at least lo cycles and release by hi
  task automatic rel(input int ch, input int lo, input int hi);
    int k;
    k = 0;
    while (((ch == 1) ? line1 : line2) === 1'b0 && k < hi + 10) begin
      @(negedge clock);
      k++;
    end
    tests_run++;
    if (k < lo || k > hi) begin
      n_fail++;
      $display("[FAIL] release ch%0d exp %0d..%0d got %0d", ch, lo, hi, k);
    end
  endtask : rel
  task automatic tally_and_finish();
    if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    {n_fail, tests_run, cyc} = '0;
    rs = 32'h0000F326;
    {rst_n, mr1_oe, mr2_oe} = 3'b000;
    {sup1, sup2, mr1, mr2} = 4'hF;
    ticks(5);
    chk("por line1", 1'b0, line1);
    chk("por line2", 1'b0, line2);
    // build-time choices against the rule's durations at the 50 ns clock
    for (int s = 0; s < 3; s++) begin
      exp_cyc = (s == 0) ? 400000 : ((s == 1) ? 2800000 : 22000000);
      len     = int'(drs_pkg::drs_timeout_cycles(drs_pkg::drs_timeout_t'(s)));
      tests_run++;
      if (len != exp_cyc) begin
        n_fail++;
        $display("[FAIL] timeout sel %0d exp %0d got %0d", s, exp_cyc, len);
      end
    end
    rst_n = 1'b1;
    rel(1, T1, T1 + LS);
    rel(2, T2 - T1 - LS, T2 - T1 + LS);
    // short dips, bounces and an undriven pin with garbage data all rejected
    for (int i = 0; i < 8; i++) begin
      len = (i == 0) ? 2 : int'(rnd() % 60) + 1;
      sup1 = 1'b0;
      ticks(int'(rnd() % 15) + 1);
      sup1 = 1'b1;
      {mr1_oe, mr1} = 2'b10;
      ticks(len);
      mr1_oe = 1'b0;
      mr1 = 1'(rnd());
      ticks(int'(rnd() % 20) + 1);
    end
    ticks(120);
    chk("glitch line1", 1'b1, line1);
    // long supply loss, then a second dip mid-timeout restarts the count
    sup1 = 1'b0;
    ticks(30);
    chk("sup low line1", 1'b0, line1);
    chk("other line2", 1'b1, line2);
    sup1 = 1'b1;
    ticks(T1 / 2);
    sup1 = 1'b0;
    ticks(30);
    sup1 = 1'b1;
    rel(1, T1, T1 + LS);
    // chained manual reset, re-asserted during its own timeout
    {mr2_oe, mr2} = 2'b10;
    ticks(200);
    chk("mr line2", 1'b0, line2);
    mr2_oe = 1'b0;
    mr2 = 1'(rnd());
    ticks(T2 / 2);
    {mr2_oe, mr2} = 2'b10;
    ticks(200);
    chk("mr again line2", 1'b0, line2);
    chk("other line1", 1'b1, line1);
    mr2_oe = 1'b0;
    rel(2, T2, T2 + LM);
    // mid-run power-on reset: both lines drop at once, then a full timeout again
    rst_n = 1'b0;
    ticks(2);
    chk("rst line1", 1'b0, line1);
    chk("rst line2", 1'b0, line2);
    rst_n = 1'b1;
    rel(1, T1, T1 + LS);
    rel(2, T2 - T1 - LS, T2 - T1 + LS);
    // minimum-width manual pulse on channel 1 with good supply
    {mr1_oe, mr1} = 2'b10;
    ticks(200);
    chk("mr line1", 1'b0, line1);
    chk("mr other line2", 1'b1, line2);
    mr1_oe = 1'b0;
    rel(1, T1, T1 + LM);
    tally_and_finish();
  end
endmodule : tb_top
